// ### common/bridge_read_pkg.sv
/*
  Shared constants, carriers and helpers for the bridge read forwarding block.
  Assumes a 32-bit data path and a cache line given in bytes.
*/
package bridge_read_pkg;

  localparam int ADDR_W = 32;
  localparam int DATA_W = 32;
  localparam int BW_W = 2;
  localparam int FACTOR_W = 3;
  localparam int LINE_BYTES = 64;
  localparam int WORD_BYTES = 4;
  localparam int LINE_WORDS = LINE_BYTES / WORD_BYTES;
  // Prefetch in lines: factor 0 gives two lines, otherwise four lines per step
  localparam int NOFLOW_LINES = 2;
  localparam int LINES_PER_FACTOR = 4;
  // Lines that must have arrived before a repeated read may stream ahead of completion
  localparam int FT_ENTRY_LINES = 2;
  // Link cycles the drain counts down after the last stored word; the completion toggle comes one cycle later
  localparam logic [1:0] DONE_DELAY_CYCLES = 2'h2;
  localparam int FIFO_PTR_W = 2;

  typedef enum logic [2:0] {
    CMD_MEM_READ,
    CMD_IO_READ,
    CMD_IO_WRITE,
    CMD_CFG_READ,
    CMD_CFG_WRITE
  } src_cmd_kind_t;

  typedef struct packed {
    src_cmd_kind_t kind;
    logic [ADDR_W-1:0] addr;
    logic more;
  } src_request_t;

  typedef struct packed {
    logic [BW_W-1:0] src_bw;
    logic [BW_W-1:0] dst_bw;
    logic conv_pci;
    logic [FACTOR_W-1:0] first_factor;
    logic [FACTOR_W-1:0] reread_factor;
  } fwd_config_t;

  function automatic logic [9:0] prefetch_words(input logic [FACTOR_W-1:0] factor);
    logic [9:0] lines;
    lines = (factor == 3'h0) ? 10'(NOFLOW_LINES) : 10'(LINES_PER_FACTOR) * 10'(factor);
    return 10'(lines * 10'(LINE_WORDS));
  endfunction : prefetch_words

  function automatic logic [FIFO_PTR_W-1:0] bin_to_gray(input logic [FIFO_PTR_W-1:0] b);
    return b ^ (b >> 1);
  endfunction : bin_to_gray

endpackage : bridge_read_pkg

// ### design/bridge_read_fwd.sv
/*
  Read forwarding core of a bus bridge: delayed reads, flow-through with a
  two-entry crossing buffer, single-phase I/O and config termination, and
  system error signalling on the destination bus.
  Assumes src_* and cfg are synchronous to core_clk and dst_* to link_clk.
*/
`timescale 1ns/1ns
`default_nettype none
module bridge_read_fwd
  import bridge_read_pkg::*;
#(
  parameter int BUF_WORDS = 64
) (
  // Core clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // Destination bus clock
  input wire logic link_clk,
  // Static configuration
  input wire fwd_config_t cfg,
  // Source bus requester side
  input wire logic src_req,
  input wire src_request_t src_cmd,
  input wire logic src_ready,
  output logic src_retry,
  output logic src_valid,
  output logic [DATA_W-1:0] src_data,
  output logic src_done,
  output logic src_target_ready,
  output logic src_stop,
  // Destination bus target side
  output logic dst_req,
  output logic [ADDR_W-1:0] dst_addr,
  output logic [9:0] dst_words,
  input wire logic dst_valid,
  input wire logic [DATA_W-1:0] dst_data,
  input wire logic dst_last,
  output logic dst_ready,
  input wire logic dst_perr_lo,
  input wire logic dst_perr_hi,
  input wire logic dst_split_resp,
  // Primary system error, open drain
  output logic primary_system_error_n_out,
  output logic primary_system_error_n_oe
);

  localparam int CNT_W = $clog2(BUF_WORDS) + 1;

  typedef enum logic [1:0] {C_IDLE, C_WAIT, C_STREAM, C_SINGLE} core_state_t;
  typedef enum logic [1:0] {L_IDLE, L_FETCH, L_DRAIN} link_state_t;

  typedef struct packed {
    core_state_t state;
    logic [ADDR_W-1:0] addr;
    logic [9:0] words;
    logic flow_en;
    logic req_tgl;
    logic done_s1;
    logic done_s2;
    logic done_prev;
    logic done_seen;
    logic [FIFO_PTR_W-1:0] wg_s1;
    logic [FIFO_PTR_W-1:0] wg_s2;
    logic [FIFO_PTR_W-1:0] rptr;
    logic [FIFO_PTR_W-1:0] rptr_g;
    logic [CNT_W-1:0] wr_cnt;
    logic [CNT_W-1:0] rd_cnt;
    logic [BUF_WORDS-1:0][DATA_W-1:0] buffer;
    logic out_valid;
    logic [DATA_W-1:0] out_data;
    logic retry;
    logic done;
    logic trdy;
    logic stop;
  } core_st_t;

  typedef struct packed {
    link_state_t state;
    logic rq_s1;
    logic rq_s2;
    logic rq_prev;
    logic [ADDR_W-1:0] addr;
    logic [9:0] words;
    logic [9:0] cnt;
    logic [FIFO_PTR_W-1:0] wptr;
    logic [FIFO_PTR_W-1:0] wptr_g;
    logic [1:0][DATA_W-1:0] mem;
    logic [FIFO_PTR_W-1:0] rg_s1;
    logic [FIFO_PTR_W-1:0] rg_s2;
    logic [1:0] delay;
    logic done_tgl;
    logic serr;
  } link_st_t;

  core_st_t c_reg, c_next;
  link_st_t l_reg, l_next;
  logic link_rst_s1, link_rst;

  // Core side helpers
  logic fifo_empty;
  logic complete;
  logic [DATA_W-1:0] fifo_rdata;
  logic repeat_hit;
  logic [9:0] pf_words;
  // Link side helpers
  logic fifo_full;
  logic push;

  assign fifo_empty = bin_to_gray(c_reg.rptr) == c_reg.wg_s2;
  assign fifo_rdata = l_reg.mem[c_reg.rptr[0]];
  assign complete = c_reg.done_seen && fifo_empty;
  assign repeat_hit = src_req && src_cmd.kind == CMD_MEM_READ && src_cmd.addr == c_reg.addr;
  assign pf_words = (prefetch_words(cfg.first_factor) > 10'(BUF_WORDS)) ?
                    10'(BUF_WORDS) : prefetch_words(cfg.first_factor);

  always_comb begin
    c_next = c_reg;
    c_next.retry = 1'b0;
    c_next.done = 1'b0;
    c_next.trdy = 1'b0;
    c_next.stop = 1'b0;
    c_next.done_s1 = l_reg.done_tgl;
    c_next.done_s2 = c_reg.done_s1;
    c_next.done_prev = c_reg.done_s2;
    c_next.wg_s1 = l_reg.wptr_g;
    c_next.wg_s2 = c_reg.wg_s1;
    if (c_reg.done_s2 != c_reg.done_prev) begin
      c_next.done_seen = 1'b1;
    end
    // Drain the crossing buffer into the delayed-read store
    if (c_reg.state inside {C_WAIT, C_STREAM} && !fifo_empty) begin
      c_next.buffer[c_reg.wr_cnt[CNT_W-2:0]] = fifo_rdata;
      c_next.wr_cnt = c_reg.wr_cnt + 1'b1;
      c_next.rptr = c_reg.rptr + 1'b1;
    end
    unique case (c_reg.state)
      C_IDLE: begin
        c_next.out_valid = 1'b0;
        if (src_req && src_cmd.kind == CMD_MEM_READ) begin
          c_next.addr = src_cmd.addr;
          c_next.words = pf_words;
          c_next.flow_en = cfg.src_bw <= cfg.dst_bw && cfg.first_factor != 3'h0 &&
                           cfg.reread_factor != 3'h0;
          c_next.req_tgl = ~c_reg.req_tgl;
          c_next.retry = 1'b1;
          c_next.done_seen = 1'b0;
          c_next.wr_cnt = '0;
          c_next.rd_cnt = '0;
          c_next.state = C_WAIT;
        end else if (src_req) begin
          c_next.trdy = 1'b1;
          c_next.stop = src_cmd.more;
          c_next.state = C_SINGLE;
        end
      end
      C_SINGLE: begin
        c_next.state = C_IDLE;
      end
      C_WAIT: begin
        if (src_req) begin
          if (repeat_hit && (complete || (c_reg.flow_en &&
              c_reg.wr_cnt >= CNT_W'(FT_ENTRY_LINES * LINE_WORDS)))) begin
            c_next.state = C_STREAM;
          end else begin
            c_next.retry = 1'b1;
          end
        end
      end
      C_STREAM: begin
        c_next.retry = src_req;
        if (!c_reg.out_valid || src_ready) begin
          if (c_reg.rd_cnt < c_reg.wr_cnt) begin
            c_next.out_valid = 1'b1;
            c_next.out_data = c_reg.buffer[c_reg.rd_cnt[CNT_W-2:0]];
            c_next.rd_cnt = c_reg.rd_cnt + 1'b1;
          end else begin
            c_next.out_valid = 1'b0;
            if (complete) begin
              c_next.done = 1'b1;
              c_next.state = C_IDLE;
            end
          end
        end
      end
    endcase
    // Gray copy is registered so a decode glitch never crosses
    c_next.rptr_g = bin_to_gray(c_next.rptr);
    if (sys_rst) begin
      c_next = '0;
      c_next.state = C_IDLE;
    end
  end

  always_ff @(posedge core_clk) begin
    c_reg <= c_next;
  end

  assign src_retry = c_reg.retry;
  assign src_valid = c_reg.out_valid;
  assign src_data = c_reg.out_data;
  assign src_done = c_reg.done;
  assign src_target_ready = c_reg.trdy;
  assign src_stop = c_reg.stop;

  // Reset brought into the link domain
  always_ff @(posedge link_clk) begin
    link_rst_s1 <= sys_rst;
    link_rst <= link_rst_s1;
  end

  assign fifo_full = bin_to_gray(l_reg.wptr) == ~l_reg.rg_s2;
  assign dst_ready = l_reg.state == L_FETCH && !fifo_full;
  assign push = dst_valid && dst_ready;

  always_comb begin
    l_next = l_reg;
    l_next.rq_s1 = c_reg.req_tgl;
    l_next.rq_s2 = l_reg.rq_s1;
    l_next.rq_prev = l_reg.rq_s2;
    l_next.rg_s1 = c_reg.rptr_g;
    l_next.rg_s2 = l_reg.rg_s1;
    l_next.serr = (dst_perr_lo || dst_perr_hi) && !(dst_perr_hi && !dst_perr_lo &&
                  dst_split_resp);
    unique case (l_reg.state)
      L_IDLE: begin
        if (l_reg.rq_s2 != l_reg.rq_prev) begin
          l_next.addr = c_reg.addr;
          l_next.words = c_reg.words;
          l_next.cnt = '0;
          l_next.state = L_FETCH;
        end
      end
      L_FETCH: begin
        if (push) begin
          l_next.mem[l_reg.wptr[0]] = dst_data;
          l_next.wptr = l_reg.wptr + 1'b1;
          l_next.cnt = l_reg.cnt + 1'b1;
        end
        // Disconnect with or without data, or prefetch satisfied
        if ((dst_last && (push || !dst_valid)) ||
            (push && l_reg.cnt + 1'b1 == l_reg.words)) begin
          l_next.delay = DONE_DELAY_CYCLES;
          l_next.state = L_DRAIN;
        end
      end
      L_DRAIN: begin
        // Lets the last pointer update settle before completion crosses
        if (l_reg.delay == 2'h0) begin
          l_next.done_tgl = ~l_reg.done_tgl;
          l_next.state = L_IDLE;
        end else begin
          l_next.delay = l_reg.delay - 1'b1;
        end
      end
      default: begin
        l_next.state = L_IDLE;
      end
    endcase
    // Gray copy is registered so a decode glitch never crosses
    l_next.wptr_g = bin_to_gray(l_next.wptr);
    if (link_rst) begin
      l_next = '0;
      l_next.state = L_IDLE;
    end
  end

  always_ff @(posedge link_clk) begin
    l_reg <= l_next;
  end

  assign dst_req = l_reg.state == L_FETCH;
  assign dst_addr = l_reg.addr;
  assign dst_words = l_reg.words;
  assign primary_system_error_n_out = 1'b0;
  assign primary_system_error_n_oe = l_reg.serr;

endmodule : bridge_read_fwd
`default_nettype wire

// ### tb/bridge_read_fwd_properties.sv
/* Port checker for bridge_read_fwd.
   Assumes it is bound to the design and sees only its ports. */
`timescale 1ns/1ns
`default_nettype none
module bridge_read_fwd_properties
  import bridge_read_pkg::*;
#(
  parameter int BUF_WORDS = 64
) (
  // Watched ports
  input wire logic core_clk,
  input wire logic link_clk,
  input wire logic sys_rst,
  input wire fwd_config_t cfg,
  input wire logic src_req,
  input wire logic src_ready,
  input wire logic src_retry,
  input wire logic src_valid,
  input wire logic [DATA_W-1:0] src_data,
  input wire logic src_target_ready,
  input wire logic src_stop,
  input wire logic dst_req,
  input wire logic [9:0] dst_words,
  input wire logic dst_perr_lo,
  input wire logic dst_perr_hi,
  input wire logic dst_split_resp,
  input wire logic primary_system_error_n_oe
);
  retry_cause_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    src_retry |-> $past(src_req)) else $error("retry without attempt");
  single_phase_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    src_target_ready |-> $past(src_req) ##1 !src_target_ready) else $error("not single");
  stop_burst_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    src_stop |-> src_target_ready) else $error("stop without ready");
  held_word_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    src_valid && !src_ready |=> src_valid && $stable(src_data)) else $error("word lost");
  no_flow_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    $rose(src_valid) && (cfg.first_factor == 3'h0 || cfg.src_bw > cfg.dst_bw) |-> !dst_req)
    else $error("flow-through not allowed");
  two_line_a: assert property (@(posedge link_clk) disable iff (sys_rst)
    dst_req && cfg.first_factor == 3'h0 |-> dst_words == 10'h020) else $error("bad size");
  factor_one_a: assert property (@(posedge link_clk) disable iff (sys_rst)
    dst_req && cfg.first_factor == 3'h1 |-> dst_words == 10'h040) else $error("bad size");
  clip_size_a: assert property (@(posedge link_clk) disable iff (sys_rst)
    dst_req && cfg.first_factor > 3'h1 |-> dst_words == 10'(BUF_WORDS)) else $error("bad size");
  upper_half_a: assert property (@(posedge link_clk) disable iff (sys_rst)
    dst_perr_hi && !dst_perr_lo && dst_split_resp |=> !primary_system_error_n_oe)
    else $error("error raised for upper half");
  flow_c: cover property (@(posedge core_clk) src_valid && dst_req);
  stop_c: cover property (@(posedge core_clk) src_stop);
  serr_c: cover property (@(posedge link_clk) primary_system_error_n_oe);
endmodule : bridge_read_fwd_properties

bind bridge_read_fwd bridge_read_fwd_properties #(.BUF_WORDS(BUF_WORDS)) props (
  .core_clk(core_clk), .link_clk(link_clk), .sys_rst(sys_rst), .cfg(cfg), .src_req(src_req),
  .src_ready(src_ready), .src_retry(src_retry), .src_valid(src_valid), .src_data(src_data),
  .src_target_ready(src_target_ready), .src_stop(src_stop), .dst_req(dst_req),
  .dst_words(dst_words), .dst_perr_lo(dst_perr_lo), .dst_perr_hi(dst_perr_hi),
  .dst_split_resp(dst_split_resp), .primary_system_error_n_oe(primary_system_error_n_oe)
);
`default_nettype wire

// ### tb/dst_target_model.sv
/* Destination bus target answering the bridge's fetches.
   Assumes the bench sets stall and the disconnect point. */
`timescale 1ns/1ns
`default_nettype none
module dst_target_model
  import bridge_read_pkg::*;
(
  // Link side and controls
  input wire logic link_clk,
  input wire logic dst_req,
  input wire logic [9:0] dst_words,
  input wire logic dst_ready,
  input wire logic stall,
  input wire logic [9:0] cut,
  output logic dst_valid,
  output logic [DATA_W-1:0] dst_data,
  output logic dst_last
);
  logic [9:0] n;
  logic w;
  logic fin;
  initial begin
    {dst_valid, dst_last, w, fin, n} = '0;
    dst_data = 32'h0;
  end
  always @(posedge link_clk) begin
    // Idle data toggles so a stale word never looks valid
    if (!dst_valid || dst_ready) dst_data <= ~dst_data;
    if (dst_req !== 1'b1) begin
      {n, fin} = '0;
      {dst_valid, dst_last} <= 2'h0;
    end else if (!fin && (!dst_valid || dst_ready)) begin
      n = n + 10'(dst_valid);
      w = !w;
      if (dst_last) begin
        fin = 1'b1;
        {dst_valid, dst_last} <= 2'h0;
      end else if (n == cut) {dst_valid, dst_last} <= 2'h1;
      else if (stall && w) dst_valid <= 1'b0;
      else begin
        dst_valid <= 1'b1;
        dst_data <= 32'hD000_0000 + 32'(n);
        dst_last <= n + 10'h1 == dst_words;
      end
    end
  end
endmodule : dst_target_model
`default_nettype wire

// ### tb/pci_bridge_read_forwarding_tb.sv
/* Self-checking bench for bridge_read_fwd and a destination target.
   Assumes the package constants and a 64-word buffer. */
`timescale 1ns/1ns
`default_nettype none
module pci_bridge_read_forwarding_tb;
  import bridge_read_pkg::*;
  logic core_clk = 0, link_clk = 0, sys_rst = 1, src_req, src_ready, src_retry, src_valid;
  logic src_done, src_target_ready, src_stop, dst_req, dst_valid, dst_last, dst_ready, stall;
  logic dst_perr_lo, dst_perr_hi, dst_split_resp, serr_out, serr_oe;
  logic [DATA_W-1:0] src_data, dst_data;
  logic [ADDR_W-1:0] dst_addr;
  logic [9:0] dst_words, cut, got;
  fwd_config_t cfg;
  src_request_t src_cmd;
  int miscompares, samples_checked;
  always #10 core_clk = !core_clk;
  always begin
    #7 link_clk = 1'b1;
    #8 link_clk = 1'b0;
  end
  always @(posedge link_clk) if (dst_valid && dst_ready) got <= got + 10'h1;
  bridge_read_fwd #(.BUF_WORDS(64)) dut (.core_clk(core_clk), .sys_rst(sys_rst),
    .link_clk(link_clk), .cfg(cfg), .src_req(src_req), .src_cmd(src_cmd),
    .src_ready(src_ready), .src_retry(src_retry), .src_valid(src_valid), .src_data(src_data),
    .src_done(src_done), .src_target_ready(src_target_ready), .src_stop(src_stop),
    .dst_req(dst_req), .dst_addr(dst_addr), .dst_words(dst_words), .dst_valid(dst_valid),
    .dst_data(dst_data), .dst_last(dst_last), .dst_ready(dst_ready),
    .dst_perr_lo(dst_perr_lo), .dst_perr_hi(dst_perr_hi), .dst_split_resp(dst_split_resp),
    .primary_system_error_n_out(serr_out), .primary_system_error_n_oe(serr_oe));
  dst_target_model partner (.link_clk(link_clk), .dst_req(dst_req), .dst_words(dst_words),
    .dst_ready(dst_ready), .stall(stall), .cut(cut), .dst_valid(dst_valid),
    .dst_data(dst_data), .dst_last(dst_last));
  task check(input logic [31:0] seen, input logic [31:0] want);
    samples_checked++;
    if (seen !== want) begin
      miscompares++;
      $display("CHECK FAILED at %0t: saw %h want %h", $time, seen, want);
    end
  endtask : check
  task tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : tick
  task req(input src_cmd_kind_t k, input logic m);
    src_cmd = '{kind: k, addr: 32'h0000_1000, more: m};
    src_req = 1'b1;
    tick(1);
    src_req = 1'b0;
  endtask : req
  task wait_got(input logic [9:0] n);
    tick(1);
    for (int t = 0; t < 300 && got < n; t++) tick(1);
    check(32'(got >= n), 32'h1);
  endtask : wait_got
  task collect(input logic [9:0] n);
    logic [9:0] k;
    k = 10'h0;
    src_ready = 1'b1;
    for (int t = 0; t < 600 && src_done !== 1'b1; t++) begin
      if (src_valid === 1'b1) begin
        check(src_data, 32'hD000_0000 + 32'(k));
        k++;
      end
      tick(1);
    end
    src_ready = 1'b0;
    check(32'(k), 32'(n));
    check({31'h0, src_done}, 32'h1);
  endtask : collect
  task setup(input logic [1:0] sbw, input logic [2:0] f, input logic st, input logic [9:0] c);
    cfg = '{src_bw: sbw, dst_bw: 2'h1, conv_pci: 1'b1, first_factor: f, reread_factor: f};
    stall = st;
    cut = c;
    got = 10'h0;
    req(CMD_MEM_READ, 1'b0);
    check({31'h0, src_retry}, 32'h1);
    tick(1);
    req(CMD_MEM_READ, 1'b0);
    check({31'h0, src_retry}, 32'h1);
  endtask : setup
  task t_io;
    src_cmd_kind_t ks [4] = '{CMD_IO_READ, CMD_IO_WRITE, CMD_CFG_READ, CMD_CFG_WRITE};
    foreach (ks[i]) begin
      req(ks[i], i[0]);
      check({src_target_ready, src_stop}, {1'b1, i[0]});
      tick(1);
      check({src_target_ready, src_stop}, 32'h0);
    end
  endtask : t_io
  task t_flow;
    setup(2'h1, 3'h1, 1'b1, 10'h030);
    // Two words past the threshold so the stored count has surely reached it
    wait_got(10'h022);
    check(32'(dst_words), 32'h0000_0040);
    check(dst_addr, 32'h0000_1000);
    req(CMD_MEM_READ, 1'b0);
    check({31'h0, src_retry}, 32'h0);
    tick(1);
    check({src_valid, dst_req}, 32'h3);
    tick(20);
    collect(10'h030);
  endtask : t_flow
  task t_noflow(input logic [1:0] sbw, input logic [2:0] f, input logic [9:0] n);
    setup(sbw, f, 1'b0, 10'h3FF);
    wait_got(n - 10'h01E);
    req(CMD_MEM_READ, 1'b0);
    check({31'h0, src_retry}, 32'h1);
    wait_got(n);
    check(32'(dst_words), 32'(n));
    tick(10);
    req(CMD_MEM_READ, 1'b0);
    check({31'h0, src_retry}, 32'h0);
    collect(n);
  endtask : t_noflow
  task t_serr;
    logic [2:0] ps [3] = '{3'h4, 3'h3, 3'h2};
    logic ws [3] = '{1'b1, 1'b0, 1'b1};
    for (int i = 0; i < 3; i++) begin
      @(posedge link_clk);
      #1 {dst_perr_lo, dst_perr_hi, dst_split_resp} = ps[i];
      @(posedge link_clk);
      #1 {dst_perr_lo, dst_perr_hi, dst_split_resp} = 3'h0;
      check({serr_oe, serr_out}, {ws[i], 1'b0});
    end
  endtask : t_serr
  task results;
    $display("checks %0d, mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : results
  initial begin
    {src_req, src_ready, dst_perr_lo, dst_perr_hi, dst_split_resp, stall} = '0;
    {miscompares, samples_checked} = '0;
    {cfg, src_cmd, got} = '0;
    cut = 10'h3FF;
    tick(4);
    sys_rst = 1'b0;
    tick(4);
    t_io;
    t_flow;
    t_noflow(2'h0, 3'h0, 10'h020);
    t_noflow(2'h3, 3'h2, 10'h040);
    t_serr;
    results;
  end
  initial begin
    #100000;
    miscompares++;
    results;
  end
endmodule : pci_bridge_read_forwarding_tb
`default_nettype wire
